// file: hdl/vrl_params.svh
// offsets, field positions, reset values and tap constants for the ladder control
// assumes inclusion by the ladder control design files and the bench
`ifndef VRL_PARAMS_SVH
`define VRL_PARAMS_SVH
`define VRL_CTRL_OFFSET 32'h0000_0000
`define VRL_MODE_OFFSET 32'h0000_0004
`define VRL_STAT_OFFSET 32'h0000_0008
`define VRL_CTRL_RESET 8'h00
`define VRL_MODE_RESET 3'h7
`define VRL_BIT_ENABLE 7
`define VRL_BIT_PIN_OE 6
`define VRL_BIT_RANGE 5
`define VRL_BIT_SOURCE 4
`define VRL_LEVEL_MSB 3
`define VRL_LEVEL_LSB 0
`define VRL_MODE_MUX4 3'h6
`define VRL_HIGH_DEN 6'h18
`define VRL_LOW_DEN 6'h20
`define VRL_LOW_BASE 5'h08
`endif

// file: hdl/vrl_pkg.sv
// types shared by the ladder control files
// assumes the params header is included where offsets are needed
package vrl_pkg;
  typedef enum logic [1:0] {
    VRL_RD_IDLE,
    VRL_RD_RESP
  } vrl_rd_state_t;
  typedef enum logic [1:0] {
    VRL_WR_IDLE,
    VRL_WR_RESP
  } vrl_wr_state_t;
  typedef logic [3:0] vrl_level_t;
endpackage

// file: hdl/vrl_tap_select.sv
// maps level code and range onto one of 32 ladder taps
// assumes registered control fields from the main module
`timescale 1ns/1ps
`include "vrl_params.svh"
module vrl_tap_select (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic range_select,
  input wire vrl_pkg::vrl_level_t level_code,
  output logic [4:0] tap_reg,
  output logic [5:0] tap_den_reg
);
  // range 1, the high range: code/24; range 0, the low range: (8+code)/32
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tap_reg <= `VRL_LOW_BASE;
      tap_den_reg <= `VRL_LOW_DEN;
    end else if (clk_en) begin
      if (range_select) begin
        tap_reg <= {1'b0, level_code};
        tap_den_reg <= `VRL_HIGH_DEN;
      end else begin
        tap_reg <= `VRL_LOW_BASE + {1'b0, level_code};
        tap_den_reg <= `VRL_LOW_DEN;
      end
    end
  end
endmodule

// file: hdl/vrl_ladder_ctrl.sv
// AXI4-Lite controlled resistor-ladder reference control
// assumes one clock, an AXI4-Lite master, and analog switches driven by the outputs
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "vrl_params.svh"
module vrl_ladder_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sleep_wake,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ladder_power_enable,
  output logic pin_output_enable,
  output logic source_select,
  output logic range_select,
  output logic [3:0] level_code,
  output logic [4:0] ladder_tap,
  output logic [5:0] ladder_den,
  output logic comparator_ref_select
);
  logic [7:0] reference_control_reg;
  logic [2:0] comparator_mode_code_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_held_reg;
  logic w_held_reg;
  vrl_pkg::vrl_wr_state_t wr_state_reg;
  vrl_pkg::vrl_rd_state_t rd_state_reg;
  logic do_write;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [2:0] wake_sync_reg;
  logic wake_level_reg;
  logic wake_prev_reg;

  function automatic logic [1:0] decode_addr(input logic [31:0] addr);
    if (addr[31:2] == `VRL_CTRL_OFFSET >> 2) begin
      decode_addr = 2'h1;
    end else if (addr[31:2] == `VRL_MODE_OFFSET >> 2) begin
      decode_addr = 2'h2;
    end else if (addr[31:2] == `VRL_STAT_OFFSET >> 2) begin
      decode_addr = 2'h3;
    end else begin
      decode_addr = 2'h0;
    end
  endfunction

  // address and data captured in either order
  always_comb begin
    wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    do_write = (wr_state_reg == vrl_pkg::VRL_WR_IDLE) &&
      (aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      if (do_write) begin
        aw_held_reg <= 1'b0;
      end else if (s_axi_awvalid && !aw_held_reg && !s_axi_awready &&
                   wr_state_reg == vrl_pkg::VRL_WR_IDLE) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
      if (do_write && !aw_held_reg) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_wready <= 1'b0;
      if (do_write) begin
        w_held_reg <= 1'b0;
      end else if (s_axi_wvalid && !w_held_reg && !s_axi_wready &&
                   wr_state_reg == vrl_pkg::VRL_WR_IDLE) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      if (do_write && !w_held_reg) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_state_reg <= vrl_pkg::VRL_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clk_en) begin
      case (wr_state_reg)
        vrl_pkg::VRL_WR_IDLE: begin
          if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (decode_addr(wr_addr) == 2'h1 ||
                            decode_addr(wr_addr) == 2'h2) ? 2'h0 : 2'h2;
            wr_state_reg <= vrl_pkg::VRL_WR_RESP;
          end
        end
        vrl_pkg::VRL_WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= vrl_pkg::VRL_WR_IDLE;
          end
        end
        default: begin
          wr_state_reg <= vrl_pkg::VRL_WR_IDLE;
        end
      endcase
    end
  end

  // control register; sleep_wake has no effect on it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reference_control_reg <= `VRL_CTRL_RESET;
    end else if (clk_en) begin
      if (do_write && decode_addr(wr_addr) == 2'h1 && wr_strb[0]) begin
        reference_control_reg <= wr_data[7:0];
      end
    end
  end

  // wake pin synchroniser; a change counts once the last two stages agree
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wake_sync_reg <= 3'h0;
      wake_level_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
    end else if (clk_en) begin
      wake_sync_reg <= {wake_sync_reg[1:0], sleep_wake};
      if (wake_sync_reg[1] == wake_sync_reg[2]) begin
        wake_level_reg <= wake_sync_reg[2];
      end
      wake_prev_reg <= wake_level_reg;
    end
  end

  // comparator mode code held for reference routing only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      comparator_mode_code_reg <= `VRL_MODE_RESET;
    end else if (clk_en) begin
      if (do_write && decode_addr(wr_addr) == 2'h2 && wr_strb[0]) begin
        comparator_mode_code_reg <= wr_data[2:0];
      end
    end
  end

  // read channel
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_state_reg <= vrl_pkg::VRL_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= 1'b0;
      case (rd_state_reg)
        vrl_pkg::VRL_RD_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            rd_state_reg <= vrl_pkg::VRL_RD_RESP;
            case (decode_addr(s_axi_araddr))
              2'h1: s_axi_rdata <= {24'h00_0000, reference_control_reg};
              2'h2: s_axi_rdata <= {29'h0000_0000, comparator_mode_code_reg};
              2'h3: s_axi_rdata <= {31'h0000_0000, comparator_ref_select};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h2;
              end
            endcase
          end
        end
        vrl_pkg::VRL_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_reg <= vrl_pkg::VRL_RD_IDLE;
          end
        end
        default: begin
          rd_state_reg <= vrl_pkg::VRL_RD_IDLE;
        end
      endcase
    end
  end

  // field outputs, independent of comparator mode, plus comparator_ref_select decoded from the mode code
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ladder_power_enable <= 1'b0;
      pin_output_enable <= 1'b0;
      source_select <= 1'b0;
      range_select <= 1'b0;
      level_code <= 4'h0;
      comparator_ref_select <= 1'b0;
    end else if (clk_en) begin
      ladder_power_enable <= reference_control_reg[`VRL_BIT_ENABLE];
      pin_output_enable <= reference_control_reg[`VRL_BIT_PIN_OE];
      source_select <= reference_control_reg[`VRL_BIT_SOURCE];
      range_select <= reference_control_reg[`VRL_BIT_RANGE];
      level_code <= reference_control_reg[`VRL_LEVEL_MSB:`VRL_LEVEL_LSB];
      comparator_ref_select <= (comparator_mode_code_reg == `VRL_MODE_MUX4);
    end
  end

  vrl_tap_select u_tap (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .range_select(reference_control_reg[`VRL_BIT_RANGE]),
    .level_code(reference_control_reg[`VRL_LEVEL_MSB:`VRL_LEVEL_LSB]),
    .tap_reg(ladder_tap),
    .tap_den_reg(ladder_den)
  );

  property p_enable_follows;
    @(posedge clock) disable iff (sys_rst)
      clk_en |=> ladder_power_enable == $past(reference_control_reg[7]);
  endproperty
  enable_follow_a: assert property (p_enable_follows) else $error("enable mismatch");

  pin_oe_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> pin_output_enable == $past(reference_control_reg[6]))
    else $error("pin enable mismatch");

  source_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> source_select == $past(reference_control_reg[4]))
    else $error("source mismatch");

  level_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> level_code == $past(reference_control_reg[3:0]))
    else $error("level mismatch");

  high_range_a: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && reference_control_reg[5]) |=>
      ladder_den == 6'h18 && ladder_tap == {1'b0, $past(reference_control_reg[3:0])})
    else $error("high range tap wrong");

  low_range_a: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && !reference_control_reg[5]) |=>
      ladder_den == 6'h20 && ladder_tap == 5'h08 + {1'b0, $past(reference_control_reg[3:0])})
    else $error("low range tap wrong");

  sequence s_ctrl_write;
    clk_en && do_write && decode_addr(wr_addr) == 2'h1 && wr_strb[0];
  endsequence
  write_takes_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_ctrl_write |=> reference_control_reg == $past(wr_data[7:0]))
    else $error("control write lost");

  hold_nowrite_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(do_write && clk_en) |=> $stable(reference_control_reg))
    else $error("control changed without write");

  wake_keeps_a: assert property (@(posedge clock) disable iff (sys_rst)
    (clk_en && wake_level_reg && !wake_prev_reg && !do_write) |=>
      $stable(reference_control_reg))
    else $error("control changed on wake");

  mode_ref_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en |=> comparator_ref_select == ($past(comparator_mode_code_reg) == 3'h6))
    else $error("reference routing wrong");
endmodule

// file: dv/tb_top.sv
// bench for the ladder control: axi4-lite register access and field outputs
// assumes the package and params header are compiled ahead of this file
`timescale 1ns/1ps
`include "vrl_params.svh"
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic sleep_wake = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_d;
  logic [1:0] rd_r;
  logic ladder_power_enable, pin_output_enable, source_select, range_select;
  logic comparator_ref_select;
  logic [3:0] level_code;
  logic [4:0] ladder_tap;
  logic [5:0] ladder_den;
  logic [7:0] vals [6] = '{8'hFF, 8'hA0, 8'h5F, 8'h2F, 8'h90, 8'h0F};
  int num_errors = 0;
  int check_count = 0;

  always #2 clock = ~clock;

  vrl_ladder_ctrl u_dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .sleep_wake(sleep_wake),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ladder_power_enable(ladder_power_enable), .pin_output_enable(pin_output_enable),
    .source_select(source_select), .range_select(range_select), .level_code(level_code),
    .ladder_tap(ladder_tap), .ladder_den(ladder_den),
    .comparator_ref_select(comparator_ref_select)
  );

  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_resp);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    b_hit = 1'b0;
    resp = 2'h3;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hit) begin
      @(negedge clock);
      aw_hit = s_axi_awready;
      w_hit = s_axi_wready;
      b_hit = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, resp}, {30'h0, exp_resp}, "write resp");
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, r_hit;
    r_hit = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hit) begin
      @(negedge clock);
      ar_hit = s_axi_arready;
      r_hit = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    axi_read(a, rd_d, rd_r);
    chk(rd_d, exp, "read data");
    chk({30'h0, rd_r}, 32'h0, "read resp");
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic chk_fields(input logic [7:0] v);
    chk({31'h0, ladder_power_enable}, {31'h0, v[7]}, "power enable");
    chk({31'h0, pin_output_enable}, {31'h0, v[6]}, "pin output");
    chk({31'h0, source_select}, {31'h0, v[4]}, "source");
    chk({27'h0, range_select, level_code}, {27'h0, v[5], v[3:0]}, "range level");
    chk({21'h0, ladder_tap, ladder_den}, v[5] ? {21'h0, 1'b0, v[3:0], 6'h18} :
        {21'h0, 5'h08 + {1'b0, v[3:0]}, 6'h20}, "tap den");
  endtask

  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    chk_fields(8'h00);
    rd_chk(`VRL_CTRL_OFFSET, 32'h0);
    rd_chk(`VRL_MODE_OFFSET, 32'h7);
    for (int i = 0; i < 6; i++) begin
      axi_write(`VRL_CTRL_OFFSET, {24'hA5A5A5, vals[i]}, 4'hF, 2'h0);
      settle();
      chk_fields(vals[i]);
      rd_chk(`VRL_CTRL_OFFSET, {24'h0, vals[i]});
    end
    axi_write(`VRL_CTRL_OFFSET, 32'h0000_00D7, 4'hF, 2'h0);
    axi_write(`VRL_STAT_OFFSET, 32'h0000_0000, 4'hF, 2'h2);
    axi_write(`VRL_CTRL_OFFSET, 32'h0000_0011, 4'hE, 2'h0);
    axi_write(32'h0000_0010, 32'h0000_0000, 4'hF, 2'h2);
    axi_read(32'h0000_0010, rd_d, rd_r);
    chk({30'h0, rd_r}, 32'h2, "unmapped read resp");
    rd_chk(`VRL_CTRL_OFFSET, 32'h0000_00D7);
    for (int m = 0; m < 8; m++) begin
      axi_write(`VRL_MODE_OFFSET, m, 4'hF, 2'h0);
      settle();
      chk({31'h0, comparator_ref_select}, {31'h0, m == 6}, "ref select");
      rd_chk(`VRL_STAT_OFFSET, {31'h0, m == 6});
      chk_fields(8'hD7);
    end
    axi_write(`VRL_CTRL_OFFSET, 32'h0000_0057, 4'hF, 2'h0);
    settle();
    @(posedge clock);
    sleep_wake <= 1'b1;
    repeat (5) @(posedge clock);
    sleep_wake <= 1'b0;
    settle();
    chk_fields(8'h57);
    rd_chk(`VRL_CTRL_OFFSET, 32'h0000_0057);
    @(posedge clock);
    clk_en <= 1'b0;
    s_axi_awaddr <= `VRL_CTRL_OFFSET;
    s_axi_wdata <= 32'h0000_0033;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk({29'h0, s_axi_awready, s_axi_wready, s_axi_bvalid}, 32'h0, "frozen bus");
    chk_fields(8'h57);
    @(posedge clock);
    clk_en <= 1'b1;
    axi_write(`VRL_CTRL_OFFSET, 32'h0000_0033, 4'hF, 2'h0);
    settle();
    chk_fields(8'h33);
    rd_chk(`VRL_CTRL_OFFSET, 32'h0000_0033);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(negedge clock);
    chk({24'h0, ladder_power_enable, pin_output_enable, range_select, source_select,
        level_code}, 32'h0, "fields in reset");
    chk({21'h0, ladder_tap, ladder_den}, {21'h0, 5'h08, 6'h20}, "tap den in reset");
    @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    chk_fields(8'h00);
    rd_chk(`VRL_CTRL_OFFSET, 32'h0);
    rd_chk(`VRL_MODE_OFFSET, 32'h7);
    give_verdict();
  end

  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
endmodule
